// file: common/gir_pkg.sv
//==========================================================================
// What this block does
// - Pin A map bit 3 routes high rate.
// - Pin A map bit 1 routes slope.
// - Shared map upper nibble routes to pin B.
// - Shared map lower nibble routes to pin A.
// - Pin B map bit 3 routes high rate.
// - Pin B map bit 1 routes slope.
// - Source bit 5 picks slow compensation input.
// - Source bit 3 picks high rate input.
// - Source bit 1 picks slope input.
// - Threshold bit 7 picks fast compensation input.
// - Slope threshold is (field plus one) times 16.
// - Awake code gives 8, 16, 32, 64 samples.
// - Slope duration code gives 4 to 16 samples.
// - Bits 2..0 enable z, y, x slope axes.
// - Slope enabled when any axis bit set.
// - Level bit picks active low or high pin.
// - Enable bits gate new data, queue and self compensation sources.
package gir_pkg;

  //==========================================================================
  // Bus geometry and register indices; byte address is four times the index.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W  = 6;
  localparam int unsigned SRC_N  = 6;
  localparam logic [IDX_W-1:0] IDX_EN     = 6'h15;
  localparam logic [IDX_W-1:0] IDX_POL    = 6'h16;
  localparam logic [IDX_W-1:0] IDX_MAP_A  = 6'h17;
  localparam logic [IDX_W-1:0] IDX_MAP_AB = 6'h18;
  localparam logic [IDX_W-1:0] IDX_MAP_B  = 6'h19;
  localparam logic [IDX_W-1:0] IDX_DSRC   = 6'h1a;
  localparam logic [IDX_W-1:0] IDX_THR    = 6'h1b;
  localparam logic [IDX_W-1:0] IDX_DUR    = 6'h1c;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h30;
  localparam logic [IDX_W-1:0] IDX_MASK   = 6'h31;
  localparam logic [1:0]       RESP_OKAY  = 2'h0;
  localparam logic [1:0]       RESP_SLVERR = 2'h2;

  //==========================================================================
  // Reset values and writable-bit masks; reserved bits always read zero.
  localparam logic [7:0] RST_EN   = 8'h00;
  localparam logic [7:0] RST_POL  = 8'h0f;
  localparam logic [7:0] RST_MAP  = 8'h00;
  localparam logic [7:0] RST_DSRC = 8'h00;
  localparam logic [7:0] RST_THR  = 8'h04;
  localparam logic [7:0] RST_DUR  = 8'ha0;
  localparam logic [7:0] RST_IRQ  = 8'h00;
  localparam logic [7:0] MSK_EN   = 8'hc2;
  localparam logic [7:0] MSK_POL  = 8'h0f;
  localparam logic [7:0] MSK_MAP1 = 8'h0a;
  localparam logic [7:0] MSK_AB   = 8'hff;
  localparam logic [7:0] MSK_DSRC = 8'h2a;
  localparam logic [7:0] MSK_THR  = 8'hff;
  localparam logic [7:0] MSK_DUR  = 8'hf7;
  localparam logic [7:0] MSK_IRQ  = 8'h3f;

  //==========================================================================
  // Field positions.
  localparam int unsigned MAP_HIGH_BIT  = 3;
  localparam int unsigned MAP_SLOPE_BIT = 1;
  localparam int unsigned EN_NEW_BIT    = 7;
  localparam int unsigned EN_QUEUE_BIT  = 6;
  localparam int unsigned EN_SELF_BIT   = 1;
  localparam int unsigned POL_A_BIT     = 0;
  localparam int unsigned POL_B_BIT     = 2;
  localparam int unsigned SLOW_UNF_BIT  = 5;
  localparam int unsigned HIGH_UNF_BIT  = 3;
  localparam int unsigned SLOPE_UNF_BIT = 1;
  localparam int unsigned FAST_UNF_BIT  = 7;
  localparam logic [11:0] THR_STEP      = 12'h010;
  localparam logic [6:0]  AWAKE_BASE    = 7'h08;
  localparam logic [4:0]  SLOPE_STEP    = 5'h04;
  localparam logic        PIN_RST       = 1'b0;

  //==========================================================================
  // Carriers.
  typedef struct packed {
    logic slope;
    logic high_rate;
    logic self_comp;
    logic queue;
    logic quick_comp;
    logic new_sample;
  } gir_src_type;

  typedef struct packed {
    logic        slow_unfilt;
    logic        high_unfilt;
    logic        slope_unfilt;
    logic        quick_unfilt;
    logic [11:0] slope_threshold;
    logic [6:0]  awake_samples;
    logic [4:0]  slope_samples;
    logic [2:0]  axis_en;
    logic        slope_enable;
  } gir_cfg_type;

  //==========================================================================
  // Helpers shared by the register file and its read path.
  function automatic logic gir_idx_hit(input logic [IDX_W-1:0] idx);
    return (idx >= IDX_EN && idx <= IDX_DUR) || idx == IDX_STATUS ||
           idx == IDX_MASK;
  endfunction

  function automatic logic [7:0] gir_wr(input logic [7:0] cur,
                                        input logic [7:0] data,
                                        input logic       hit,
                                        input logic [7:0] mask);
    return hit ? (data & mask) : cur;
  endfunction

  function automatic gir_cfg_type gir_decode(input logic [7:0] dsrc,
                                             input logic [7:0] thr,
                                             input logic [7:0] dur);
    gir_cfg_type c;
    c.slow_unfilt     = dsrc[SLOW_UNF_BIT];
    c.high_unfilt     = dsrc[HIGH_UNF_BIT];
    c.slope_unfilt    = dsrc[SLOPE_UNF_BIT];
    c.quick_unfilt    = thr[FAST_UNF_BIT];
    // A full field gives 2048, so the threshold needs twelve bits.
    c.slope_threshold = 12'((12'(thr[6:0]) + 12'h001) * THR_STEP);
    c.awake_samples   = AWAKE_BASE << dur[7:6];
    c.slope_samples   = 5'((5'(dur[5:4]) + 5'h01) * SLOPE_STEP);
    c.axis_en         = dur[2:0];
    c.slope_enable    = |dur[2:0];
    return c;
  endfunction

endpackage

// file: rtl/gir_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
module gir_axil_slave
  import gir_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  output wire logic              wr_fire,
  output wire logic [IDX_W-1:0]  wr_idx,
  output wire logic [7:0]        wr_data,
  output wire logic              wr_lane,
  output wire logic              rd_fire,
  output wire logic [IDX_W-1:0]  rd_idx,
  input  wire logic [7:0]        rd_data
);
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] ar_addr;
  logic [7:0]        w_data;
  logic              w_lane;

  //==========================================================================
  // A request is acted on once both halves are held and no answer is out.
  assign wr_fire = !awready && !wready && !bvalid;
  assign wr_idx  = aw_addr[ADDR_W-1:2];
  assign wr_data = w_data;
  assign wr_lane = w_lane;
  assign rd_fire = !arready && !rvalid;
  assign rd_idx  = ar_addr[ADDR_W-1:2];

  // Write channels: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      aw_addr <= '0;
      w_data  <= '0;
      w_lane  <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_data <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= gir_idx_hit(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // Read channel: data is captured one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
      ar_addr <= '0;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        ar_addr <= araddr;
      end
      if (rd_fire) begin
        rvalid <= 1'b1;
        rdata  <= {24'h000000, rd_data};
        rresp  <= gir_idx_hit(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/gir_pin_drive.sv
`timescale 1ns/1ps
`default_nettype none
module gir_pin_drive
  import gir_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [SRC_N-1:0] src,
  input  wire logic [SRC_N-1:0] enable,
  input  wire logic [SRC_N-1:0] route,
  input  wire logic             active_high,
  output var  logic             pin
);
  logic any_src;
  logic next_pin;

  //==========================================================================
  // The pin is the OR of enabled, routed sources, then given its polarity.
  assign any_src  = |(src & enable & route);
  assign next_pin = active_high ? any_src : !any_src;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin <= PIN_RST;
    end else begin
      pin <= next_pin;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // An idle pin rests at the opposite of its active level.
  idle_level_a: assert property (
      !any_src |=> pin == !$past(active_high))
    else $error("idle pin not at inactive level");
endmodule
`default_nettype wire

// file: rtl/gir_irq_route.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module gir_irq_route
  import gir_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output wire logic              wready,
  output wire logic [1:0]        bresp,
  output wire logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output wire logic              arready,
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  output wire logic              rvalid,
  input  wire logic              rready,
  input  wire gir_src_type       src,
  output wire logic              first_irq_pin,
  output wire logic              second_irq_pin,
  output var  gir_cfg_type       cfg,
  output var  logic              irq
);

  //==========================================================================
  // Register bus.
  logic             wr_fire;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0]       wr_data;
  logic             wr_lane;
  logic             rd_fire;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0]       rd_data;

  gir_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_fire (wr_fire),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_lane (wr_lane),
    .rd_fire (rd_fire),
    .rd_idx  (rd_idx),
    .rd_data (rd_data)
  );

  //==========================================================================
  // Register file.
  logic [7:0] src_en;
  logic [7:0] pin_cfg;
  logic [7:0] pin_a_motion_map;
  logic [7:0] pin_ab_source_map;
  logic [7:0] pin_b_motion_map;
  logic [7:0] interrupt_data_source;
  logic [7:0] motion_threshold_cfg;
  logic [7:0] motion_duration_axis_cfg;
  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic [7:0] next_src_en;
  logic [7:0] next_pin_cfg;
  logic [7:0] next_map_a;
  logic [7:0] next_map_ab;
  logic [7:0] next_map_b;
  logic [7:0] next_dsrc;
  logic [7:0] next_thr;
  logic [7:0] next_dur;
  logic [7:0] next_status;
  logic [7:0] next_mask;
  logic       wr_ok;
  logic [7:0] status_clr;

  // Only the low byte lane carries register data; other lanes are ignored.
  assign wr_ok = wr_fire && wr_lane;

  // Reserved bits are masked off, so stray ones written there are dropped.
  assign next_src_en = gir_wr(src_en, wr_data, wr_ok && wr_idx == IDX_EN,
                              MSK_EN);
  assign next_pin_cfg = gir_wr(pin_cfg, wr_data,
                               wr_ok && wr_idx == IDX_POL, MSK_POL);
  assign next_map_a = gir_wr(pin_a_motion_map, wr_data,
                             wr_ok && wr_idx == IDX_MAP_A, MSK_MAP1);
  assign next_map_ab = gir_wr(pin_ab_source_map, wr_data,
                              wr_ok && wr_idx == IDX_MAP_AB, MSK_AB);
  assign next_map_b = gir_wr(pin_b_motion_map, wr_data,
                             wr_ok && wr_idx == IDX_MAP_B, MSK_MAP1);
  assign next_dsrc = gir_wr(interrupt_data_source, wr_data,
                            wr_ok && wr_idx == IDX_DSRC, MSK_DSRC);
  assign next_thr = gir_wr(motion_threshold_cfg, wr_data,
                           wr_ok && wr_idx == IDX_THR, MSK_THR);
  assign next_dur = gir_wr(motion_duration_axis_cfg, wr_data,
                           wr_ok && wr_idx == IDX_DUR, MSK_DUR);
  assign next_mask = gir_wr(irq_mask, wr_data,
                            wr_ok && wr_idx == IDX_MASK, MSK_IRQ);

  // Reading the status register clears it; a source active in that same
  // cycle sets its bit again, so no event is lost to the clear.
  assign status_clr  = (rd_fire && rd_idx == IDX_STATUS) ? MSK_IRQ : 8'h00;
  assign next_status = (irq_status & ~status_clr) |
                       {2'h0, 6'(src)};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_en                   <= RST_EN;
      pin_cfg                  <= RST_POL;
      pin_a_motion_map         <= RST_MAP;
      pin_ab_source_map        <= RST_MAP;
      pin_b_motion_map         <= RST_MAP;
      interrupt_data_source    <= RST_DSRC;
      motion_threshold_cfg     <= RST_THR;
      motion_duration_axis_cfg <= RST_DUR;
      irq_status               <= RST_IRQ;
      irq_mask                 <= RST_IRQ;
    end else begin
      src_en                   <= next_src_en;
      pin_cfg                  <= next_pin_cfg;
      pin_a_motion_map         <= next_map_a;
      pin_ab_source_map        <= next_map_ab;
      pin_b_motion_map         <= next_map_b;
      interrupt_data_source    <= next_dsrc;
      motion_threshold_cfg     <= next_thr;
      motion_duration_axis_cfg <= next_dur;
      irq_status               <= next_status;
      irq_mask                 <= next_mask;
    end
  end

  // Read selection; the bus answers unmapped indices with zero data.
  assign rd_data = (rd_idx == IDX_EN)     ? src_en :
                   (rd_idx == IDX_POL)    ? pin_cfg :
                   (rd_idx == IDX_MAP_A)  ? pin_a_motion_map :
                   (rd_idx == IDX_MAP_AB) ? pin_ab_source_map :
                   (rd_idx == IDX_MAP_B)  ? pin_b_motion_map :
                   (rd_idx == IDX_DSRC)   ? interrupt_data_source :
                   (rd_idx == IDX_THR)    ? motion_threshold_cfg :
                   (rd_idx == IDX_DUR)    ? motion_duration_axis_cfg :
                   (rd_idx == IDX_STATUS) ? irq_status :
                   (rd_idx == IDX_MASK)   ? irq_mask : 8'h00;

  //==========================================================================
  // Configuration handed to the detection and compensation logic.
  // Registered so the outputs are glitch free; they lag the register by one
  // cycle, which the slow sample rate of the detectors easily absorbs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= gir_decode(RST_DSRC, RST_THR, RST_DUR);
    end else begin
      cfg <= gir_decode(interrupt_data_source, motion_threshold_cfg,
                        motion_duration_axis_cfg);
    end
  end

  // Level interrupt to the local processor, high while any unmasked status
  // bit is set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & next_mask);
    end
  end

  //==========================================================================
  // Pin routing.
  logic [SRC_N-1:0] src_vec;
  logic [SRC_N-1:0] en_vec;
  logic [SRC_N-1:0] route_a;
  logic [SRC_N-1:0] route_b;
  logic             slope_on;

  // Slope detection counts as enabled while any axis is enabled.
  assign slope_on = |motion_duration_axis_cfg[2:0];
  assign src_vec  = src;

  // New data and queue obey their own enables; high rate and quick
  // compensation have no enable in this block and pass straight through.
  assign en_vec = {slope_on, 1'b1, src_en[EN_SELF_BIT],
                   src_en[EN_QUEUE_BIT], 1'b1,
                   src_en[EN_NEW_BIT]};

  // The shared map holds pin A sources in the low nibble in source order.
  assign route_a = {pin_a_motion_map[MAP_SLOPE_BIT],
                    pin_a_motion_map[MAP_HIGH_BIT],
                    pin_ab_source_map[3:0]};

  // Its high nibble holds pin B sources in reversed order.
  assign route_b = {pin_b_motion_map[MAP_SLOPE_BIT],
                    pin_b_motion_map[MAP_HIGH_BIT],
                    pin_ab_source_map[4], pin_ab_source_map[5],
                    pin_ab_source_map[6],
                    pin_ab_source_map[7]};

  gir_pin_drive u_pin_a (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .src         (src_vec),
    .enable      (en_vec),
    .route       (route_a),
    .active_high (pin_cfg[POL_A_BIT]),
    .pin         (first_irq_pin)
  );

  gir_pin_drive u_pin_b (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .src         (src_vec),
    .enable      (en_vec),
    .route       (route_b),
    .active_high (pin_cfg[POL_B_BIT]),
    .pin         (second_irq_pin)
  );

  //==========================================================================
  // Checks.
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic any_a;
  logic any_b;
  assign any_a = |(src_vec & en_vec & route_a);
  assign any_b = |(src_vec & en_vec & route_b);

  sequence wr_to(logic [IDX_W-1:0] idx);
    wr_fire && wr_lane && wr_idx == idx;
  endsequence

  // A mapped source shows at its pin's active level one edge later.
  high_to_a_a: assert property (
      src.high_rate && pin_a_motion_map[MAP_HIGH_BIT] |=>
      first_irq_pin == $past(pin_cfg[POL_A_BIT]))
    else $error("high rate not routed to pin A");
  slope_to_a_a: assert property (
      src.slope && slope_on && pin_a_motion_map[MAP_SLOPE_BIT] |=>
      first_irq_pin == $past(pin_cfg[POL_A_BIT]))
    else $error("slope not routed to pin A");
  new_to_b_a: assert property (
      src.new_sample && src_en[EN_NEW_BIT] && pin_ab_source_map[7] |=>
      second_irq_pin == $past(pin_cfg[POL_B_BIT]))
    else $error("new data not routed to pin B");
  queue_to_b_a: assert property (
      src.queue && src_en[EN_QUEUE_BIT] && pin_ab_source_map[5] |=>
      second_irq_pin == $past(pin_cfg[POL_B_BIT]))
    else $error("queue not routed to pin B");
  queue_to_a_a: assert property (
      src.queue && src_en[EN_QUEUE_BIT] && pin_ab_source_map[2] |=>
      first_irq_pin == $past(pin_cfg[POL_A_BIT]))
    else $error("queue not routed to pin A");
  quick_to_a_a: assert property (
      src.quick_comp && pin_ab_source_map[1] |=>
      first_irq_pin == $past(pin_cfg[POL_A_BIT]))
    else $error("quick compensation not routed to pin A");
  high_to_b_a: assert property (
      src.high_rate && pin_b_motion_map[MAP_HIGH_BIT] |=>
      second_irq_pin == $past(pin_cfg[POL_B_BIT]))
    else $error("high rate not routed to pin B");
  slope_to_b_a: assert property (
      src.slope && slope_on && pin_b_motion_map[MAP_SLOPE_BIT] |=>
      second_irq_pin == $past(pin_cfg[POL_B_BIT]))
    else $error("slope not routed to pin B");

  // Decoded fields follow a write two edges after it is acted on: one
  // edge for the register and one for the output stage.
  slow_sel_a: assert property (
      wr_to(IDX_DSRC) |-> ##2
      cfg.slow_unfilt == $past(wr_data[SLOW_UNF_BIT], 2))
    else $error("slow compensation source wrong");
  high_sel_a: assert property (
      wr_to(IDX_DSRC) |-> ##2
      cfg.high_unfilt == $past(wr_data[HIGH_UNF_BIT], 2))
    else $error("high rate source wrong");
  slope_sel_a: assert property (
      wr_to(IDX_DSRC) |-> ##2
      cfg.slope_unfilt == $past(wr_data[SLOPE_UNF_BIT], 2))
    else $error("slope source wrong");
  fast_sel_a: assert property (
      wr_to(IDX_THR) |-> ##2
      cfg.quick_unfilt == $past(wr_data[FAST_UNF_BIT], 2))
    else $error("fast compensation source wrong");
  slope_thr_a: assert property (
      wr_to(IDX_THR) |-> ##2 cfg.slope_threshold ==
      (12'($past(wr_data[6:0], 2)) + 12'h001) * THR_STEP)
    else $error("slope threshold wrong");
  awake_cnt_a: assert property (
      wr_to(IDX_DUR) |-> ##2
      cfg.awake_samples == (7'h08 << $past(wr_data[7:6], 2)))
    else $error("awake sample count wrong");
  slope_cnt_a: assert property (
      wr_to(IDX_DUR) |-> ##2 cfg.slope_samples ==
      (5'($past(wr_data[5:4], 2)) + 5'h01) * 5'h04)
    else $error("slope sample count wrong");
  axis_en_a: assert property (
      wr_to(IDX_DUR) |-> ##2
      cfg.axis_en == $past(wr_data[2:0], 2))
    else $error("axis enables wrong");
  slope_en_a: assert property (
      wr_to(IDX_DUR) |-> ##2
      cfg.slope_enable == |$past(wr_data[2:0], 2))
    else $error("slope enable wrong");

  // A disabled source never reaches a pin, whatever its mapping.
  new_gate_a: assert property (
      !src_en[EN_NEW_BIT] && src_vec == 6'h01 |=>
      first_irq_pin == !$past(pin_cfg[POL_A_BIT]))
    else $error("disabled new data reached pin A");
  pin_a_or_a: assert property (
      ##1 first_irq_pin ==
      ($past(pin_cfg[POL_A_BIT]) ? $past(any_a) : !$past(any_a)))
    else $error("pin A is not the OR of its sources");
  pin_b_or_a: assert property (
      ##1 second_irq_pin ==
      ($past(pin_cfg[POL_B_BIT]) ? $past(any_b) : !$past(any_b)))
    else $error("pin B is not the OR of its sources");

  // Status and level interrupt; a set in the clearing cycle wins.
  irq_level_a: assert property (irq == |(irq_status & irq_mask))
    else $error("interrupt output disagrees with status and mask");
  clear_set_a: assert property (status_clr[0] && src.new_sample |=>
      irq_status[0])
    else $error("event lost to status clear");

endmodule
`default_nettype wire

// file: test/gir_host_mon.sv
`timescale 1ns/1ps
`default_nettype none
module gir_host_mon (
  input  wire logic aclk,
  input  wire logic first_irq_pin,
  input  wire logic second_irq_pin,
  input  wire logic pol_a,
  input  wire logic pol_b,
  output var  logic seen_a,
  output var  logic seen_b
);
  // The host sees a pin as asserted only at its chosen active level.
  always_ff @(posedge aclk) begin
    seen_a <= first_irq_pin == pol_a;
    seen_b <= second_irq_pin == pol_b;
  end
endmodule
`default_nettype wire

// file: test/gir_irq_route_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gir_irq_route_tb import gir_pkg::*;;
  //==========================================================================
  // Bench state.
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0;
  logic bready = 1, rready = 1, pola = 0, polb = 0, sa, sb, pa, pb, irq;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr = 0, araddr = 0, en, ma, ab, mb, du;
  logic [5:0] ev, ra, rb;
  logic [31:0] wdata = 0, rdata, rd, seed = 83721;
  logic [1:0] bresp, rresp, rs;
  gir_src_type src = '0;
  gir_cfg_type cfg;
  int num_errors = 0, tests_run = 0;
  gir_irq_route gir_irq_route_inst (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .src, .first_irq_pin(pa), .second_irq_pin(pb), .cfg, .irq);
  gir_host_mon gir_host_mon_inst (.aclk, .first_irq_pin(pa),
    .second_irq_pin(pb), .pol_a(pola), .pol_b(polb), .seen_a(sa),
    .seen_b(sb));
  always #5 aclk = ~aclk;
  //==========================================================================
  // Helpers; bready and rready stay high so every answer is taken at once.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic hit(input logic [5:0] s, e, r);
    return |(s & e & r);
  endfunction
  task chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [5:0] i, input logic [7:0] d);
    awaddr <= {i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
  endtask
  task rd_reg(input logic [5:0] i);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
  endtask
  task stop_test;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // A hang counts as a mismatch; the full run needs about 1300 cycles.
  initial begin
    #200000;
    num_errors++;
    stop_test;
  end
  //==========================================================================
  // Main sequence.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(IDX_THR); chk("thr_rst", 32'h04, rd);
    rd_reg(IDX_DUR); chk("dur_rst", 32'ha0, rd);
    rd_reg(6'h3f); chk("bad_resp", 32'h2, rs);
    wr(6'h3f, 8'h55); chk("bad_wr", 32'h2, rs);
    wr(IDX_MAP_A, 8'hff); rd_reg(IDX_MAP_A); chk("rsv", 32'h0a, rd);
    repeat (8) begin
      seed = lfsr(seed);
      wr(IDX_THR, seed[7:0]);
      wr(IDX_DUR, seed[15:8] & 8'hf7);
      wr(IDX_DSRC, seed[23:16] & 8'h2a);
      @(posedge aclk);
      chk("thr", (32'(seed[6:0]) + 1) * 16, cfg.slope_threshold);
      chk("fast", seed[7], cfg.quick_unfilt);
      chk("awake", 8 << seed[15:14], cfg.awake_samples);
      chk("dur", (32'(seed[13:12]) + 1) * 4, cfg.slope_samples);
      chk("axes", {|seed[10:8], seed[10:8]},
          {cfg.slope_enable, cfg.axis_en});
      chk("sel", {seed[21], seed[19], seed[17]},
          {cfg.slow_unfilt, cfg.high_unfilt, cfg.slope_unfilt});
    end
    // Random routing; each setting is probed with several source patterns.
    repeat (40) begin
      seed = lfsr(seed);
      {en, ma, ab, mb} = {seed[31:24] & 8'hc2, seed[23:16] & 8'h0a,
                          seed[15:8], seed[7:0] & 8'h0a};
      du = {5'h0, seed[2:0]};
      {pola, polb} = seed[5:4];
      wr(IDX_EN, en); wr(IDX_POL, {5'h0, polb, 1'b0, pola});
      wr(IDX_MAP_A, ma); wr(IDX_MAP_AB, ab); wr(IDX_MAP_B, mb);
      wr(IDX_DUR, du);
      ev = {|du[2:0], 1'b1, en[1], en[6], 1'b1, en[7]};
      ra = {ma[1], ma[3], ab[3:0]};
      rb = {mb[1], mb[3], ab[4], ab[5], ab[6], ab[7]};
      repeat (4) begin
        seed = lfsr(seed);
        src <= seed[5:0];
        repeat (3) @(posedge aclk);
        chk("pin_a", hit(src, ev, ra), sa);
        chk("pin_b", hit(src, ev, rb), sb);
      end
    end
    // Interrupt status: raise, mask, clear.
    src <= '0;
    wr(IDX_MASK, 8'h10); rd_reg(IDX_STATUS); repeat (2) @(posedge aclk);
    chk("irq_clr", 0, irq);
    src <= 6'h10; @(posedge aclk); src <= 6'h00; repeat (2) @(posedge aclk);
    chk("irq_set", 1, irq);
    wr(IDX_MASK, 8'h00); @(posedge aclk); chk("irq_mask", 0, irq);
    rd_reg(IDX_STATUS); chk("status", 32'h10, rd);
    // A source held through a clearing read keeps its status bit.
    src <= 6'h01; rd_reg(IDX_STATUS); src <= 6'h00;
    rd_reg(IDX_STATUS); chk("set_wins", 32'h01, rd);
    wr(IDX_MASK, 8'h10); @(posedge aclk); chk("irq_gone", 0, irq);
    stop_test;
  end
endmodule
`default_nettype wire
